/* aptr_pkg.sv */
// Package: register map, timing constants and carrier types of the threshold/timing bank
package aptr_pkg;
  localparam logic [7:0] ADDR_PROX_SAMPLE_DURATION = 8'h82;
  localparam logic [7:0] ADDR_WAIT_TIME = 8'h83;
  localparam logic [7:0] ADDR_ALS_LOW_THRESH_LO = 8'h84;
  localparam logic [7:0] ADDR_ALS_LOW_THRESH_HI = 8'h85;
  localparam logic [7:0] ADDR_ALS_HIGH_THRESH_LO = 8'h86;
  localparam logic [7:0] ADDR_ALS_HIGH_THRESH_HI = 8'h87;
  localparam logic [7:0] ADDR_PROX_LOW_THRESH = 8'h88;

  localparam logic [7:0] RST_PROX_SAMPLE_DURATION = 8'h1f;
  localparam logic [7:0] RST_WAIT_TIME = 8'h00;
  localparam logic [7:0] RST_THRESH_BYTE = 8'h00;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PROX_UNIT_NS = 88000;
  localparam int unsigned PROX_UNIT_CYC = PROX_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned WAIT_UNIT_NS = 2800000;
  localparam int unsigned WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned WAIT_LONG_FACTOR = 12;
  localparam int unsigned PERS_CNT_W = 6;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aptr_reg_req_t;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
  } aptr_als_thr_t;
endpackage

/* aptr_regs.sv */
// Threshold and timing register bank with persistence filters and interrupt pin
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R01] Prox sample lasts (duration+1) times 88 us
// [R02] Wait lasts (wait_time+1) times 2.8 ms
// [R03] Long wait multiplies wait period by twelve
// [R04] ALS threshold bytes form one 16-bit value
// [R05] Clear below low threshold, persistence met: flag
// [R06] Clear above high threshold, persistence met: flag
// [R07] Pin asserts on ALS flag with enable
// [R08] Low byte buffered until high byte written
// [R09] High byte write latches both bytes together
// [R10] Host writes low byte, then high byte
// [R11] Prox result compared to 8-bit low threshold
// [R12] Prox below low threshold, persistence met: flag
// [R13] Pin asserts on prox flag with enable
// [R14] ALS out-of-range count, cleared inside, equals setting; the code uses the setting for 0 to 3 and (setting-3)*5 for 4 and up
// [R15] Prox out-of-range count, cleared inside, equals setting
// [R16] Long-wait select is configuration bit two
// [R17] Compare once per finished measurement cycle
// [R18] Flags stay set until host clears them
module aptr_regs #(
  parameter int unsigned WAIT_UNIT_CYCLES = aptr_pkg::WAIT_UNIT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire aptr_pkg::aptr_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic long_wait_select_i,
  input wire logic [3:0] als_persistence_i,
  input wire logic [3:0] prox_persistence_i,
  input wire logic als_irq_enable_i,
  input wire logic prox_irq_enable_i,
  input wire logic als_irq_clear_i,
  input wire logic prox_irq_clear_i,
  input wire logic wait_start_i,
  input wire logic prox_sample_start_i,
  input wire logic als_done_i,
  input wire logic [15:0] als_clear_i,
  input wire logic prox_done_i,
  input wire logic [7:0] prox_result_i,
  output logic wait_busy_o,
  output logic prox_sample_busy_o,
  output logic als_irq_flag_o,
  output logic prox_irq_flag_o,
  output logic int_o
);
  localparam int unsigned PW = aptr_pkg::PERS_CNT_W;

  function automatic logic [PW-1:0] als_pers_target(input logic [3:0] v);
    if (v < 4'h4)
      als_pers_target = PW'(v);
    else
      als_pers_target = PW'((int'(v) - 3) * 5);
  endfunction

  function automatic logic [PW-1:0] pers_next(input logic outside, input logic [PW-1:0] cnt,
                                              input logic [PW-1:0] tgt);
    if (!outside)
      pers_next = '0;
    else if (cnt < tgt)
      pers_next = cnt + PW'(1);
    else
      pers_next = cnt;
  endfunction

  logic [7:0] prox_sample_duration;
  logic [7:0] wait_time;
  logic [7:0] als_low_thresh_lo;
  logic [7:0] als_low_thresh_hi;
  logic [7:0] als_high_thresh_lo;
  logic [7:0] als_high_thresh_hi;
  logic [7:0] prox_low_thresh;
  aptr_pkg::aptr_als_thr_t als_thr;

  //////////////////////////////////////////////////////////////////////////////
  // Register writes; the active ALS thresholds only move on a high-byte write
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      prox_sample_duration <= aptr_pkg::RST_PROX_SAMPLE_DURATION;
      wait_time <= aptr_pkg::RST_WAIT_TIME;
      als_low_thresh_lo <= aptr_pkg::RST_THRESH_BYTE;
      als_low_thresh_hi <= aptr_pkg::RST_THRESH_BYTE;
      als_high_thresh_lo <= aptr_pkg::RST_THRESH_BYTE;
      als_high_thresh_hi <= aptr_pkg::RST_THRESH_BYTE;
      prox_low_thresh <= aptr_pkg::RST_THRESH_BYTE;
      als_thr <= '0;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        aptr_pkg::ADDR_PROX_SAMPLE_DURATION: prox_sample_duration <= reg_req_i.wdata;
        aptr_pkg::ADDR_WAIT_TIME: wait_time <= reg_req_i.wdata;
        aptr_pkg::ADDR_ALS_LOW_THRESH_LO: als_low_thresh_lo <= reg_req_i.wdata; // [R08]
        aptr_pkg::ADDR_ALS_LOW_THRESH_HI:
        begin
          als_low_thresh_hi <= reg_req_i.wdata;
          als_thr.low <= {reg_req_i.wdata, als_low_thresh_lo}; // [R09] [R04] [R10]
        end
        aptr_pkg::ADDR_ALS_HIGH_THRESH_LO: als_high_thresh_lo <= reg_req_i.wdata; // [R08]
        aptr_pkg::ADDR_ALS_HIGH_THRESH_HI:
        begin
          als_high_thresh_hi <= reg_req_i.wdata;
          als_thr.high <= {reg_req_i.wdata, als_high_thresh_lo}; // [R09] [R04]
        end
        aptr_pkg::ADDR_PROX_LOW_THRESH: prox_low_thresh <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        aptr_pkg::ADDR_PROX_SAMPLE_DURATION: reg_rdata_o <= prox_sample_duration;
        aptr_pkg::ADDR_WAIT_TIME: reg_rdata_o <= wait_time;
        aptr_pkg::ADDR_ALS_LOW_THRESH_LO: reg_rdata_o <= als_low_thresh_lo;
        aptr_pkg::ADDR_ALS_LOW_THRESH_HI: reg_rdata_o <= als_low_thresh_hi;
        aptr_pkg::ADDR_ALS_HIGH_THRESH_LO: reg_rdata_o <= als_high_thresh_lo;
        aptr_pkg::ADDR_ALS_HIGH_THRESH_HI: reg_rdata_o <= als_high_thresh_hi;
        aptr_pkg::ADDR_PROX_LOW_THRESH: reg_rdata_o <= prox_low_thresh;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timers: a unit prescaler feeding a down counter of units
  logic [19:0] wait_pre;
  logic [7:0] wait_left;
  logic [10:0] prox_pre;
  logic [7:0] prox_left;
  logic [19:0] wait_unit_len;

  // Stretching the unit keeps the down counter at 8 bits in long-wait mode
  assign wait_unit_len = long_wait_select_i ?
    20'(WAIT_UNIT_CYCLES * aptr_pkg::WAIT_LONG_FACTOR) : 20'(WAIT_UNIT_CYCLES); // [R03] [R16]

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_busy_o <= 1'b0;
      wait_pre <= '0;
      wait_left <= 8'h00;
    end
    else if (wait_start_i && !wait_busy_o)
    begin
      wait_busy_o <= 1'b1;
      wait_pre <= wait_unit_len - 20'd1;
      wait_left <= wait_time; // [R02]
    end
    else if (wait_busy_o)
    begin
      if (wait_pre != '0)
        wait_pre <= wait_pre - 20'd1;
      else if (wait_left == 8'h00)
        wait_busy_o <= 1'b0;
      else
      begin
        wait_left <= wait_left - 8'h01; // [R02]
        wait_pre <= wait_unit_len - 20'd1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      prox_sample_busy_o <= 1'b0;
      prox_pre <= '0;
      prox_left <= 8'h00;
    end
    else if (prox_sample_start_i && !prox_sample_busy_o)
    begin
      prox_sample_busy_o <= 1'b1;
      prox_pre <= 11'(aptr_pkg::PROX_UNIT_CYC - 1);
      prox_left <= prox_sample_duration; // [R01]
    end
    else if (prox_sample_busy_o)
    begin
      if (prox_pre != '0)
        prox_pre <= prox_pre - 11'd1;
      else if (prox_left == 8'h00)
        prox_sample_busy_o <= 1'b0;
      else
      begin
        prox_left <= prox_left - 8'h01; // [R01]
        prox_pre <= 11'(aptr_pkg::PROX_UNIT_CYC - 1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Persistence filters and sticky flags; a set in the clear cycle wins
  logic als_outside;
  logic prox_outside;
  logic [PW-1:0] als_tgt;
  logic [PW-1:0] prox_tgt;
  logic [PW-1:0] als_cnt;
  logic [PW-1:0] prox_cnt;
  logic [PW-1:0] next_als_cnt;
  logic [PW-1:0] next_prox_cnt;
  logic als_hit;
  logic prox_hit;

  assign als_outside = (als_clear_i < als_thr.low) || (als_clear_i > als_thr.high); // [R05] [R06]
  assign prox_outside = prox_result_i < prox_low_thresh; // [R11]
  assign als_tgt = als_pers_target(als_persistence_i);
  assign prox_tgt = PW'(prox_persistence_i);
  assign next_als_cnt = pers_next(als_outside, als_cnt, als_tgt); // [R14]
  assign next_prox_cnt = pers_next(prox_outside, prox_cnt, prox_tgt); // [R15]
  // A zero setting fires on every finished measurement (done pulse), whatever the result
  assign als_hit = als_done_i && ((als_tgt == '0) || (als_outside && next_als_cnt == als_tgt));
  assign prox_hit = prox_done_i && ((prox_tgt == '0) || (prox_outside && next_prox_cnt == prox_tgt));

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      als_cnt <= '0;
      prox_cnt <= '0;
    end
    else
    begin
      if (als_done_i)
        als_cnt <= next_als_cnt; // [R17] [R14]
      if (prox_done_i)
        prox_cnt <= next_prox_cnt; // [R17] [R15]
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      als_irq_flag_o <= 1'b0;
      prox_irq_flag_o <= 1'b0;
    end
    else
    begin
      als_irq_flag_o <= als_hit || (als_irq_flag_o && !als_irq_clear_i); // [R05] [R06] [R18]
      prox_irq_flag_o <= prox_hit || (prox_irq_flag_o && !prox_irq_clear_i); // [R12] [R18]
    end
  end

  assign int_o = (als_irq_flag_o && als_irq_enable_i) ||
                 (prox_irq_flag_o && prox_irq_enable_i); // [R07] [R13]

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [31:0] wait_len;
  logic [31:0] wait_exp;
  logic [31:0] prox_len;
  logic [31:0] prox_exp;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_len <= '0;
      wait_exp <= '0;
      prox_len <= '0;
      prox_exp <= '0;
    end
    else
    begin
      if (wait_start_i && !wait_busy_o)
      begin
        wait_len <= '0;
        wait_exp <= (32'(wait_time) + 32'd1) * 32'(wait_unit_len);
      end
      else if (wait_busy_o)
        wait_len <= wait_len + 32'd1;
      if (prox_sample_start_i && !prox_sample_busy_o)
      begin
        prox_len <= '0;
        prox_exp <= (32'(prox_sample_duration) + 32'd1) * 32'(aptr_pkg::PROX_UNIT_CYC);
      end
      else if (prox_sample_busy_o)
        prox_len <= prox_len + 32'd1;
    end
  end

  sequence s_low_byte_write;
    reg_req_i.wr && reg_req_i.addr == aptr_pkg::ADDR_ALS_LOW_THRESH_LO;
  endsequence

  sequence s_high_byte_write;
    reg_req_i.wr && reg_req_i.addr == aptr_pkg::ADDR_ALS_LOW_THRESH_HI;
  endsequence

  chk_wait_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R02] [R03]
    $fell(wait_busy_o) |-> wait_len == wait_exp)
    else $error("wait period length wrong");

  chk_prox_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R01]
    $fell(prox_sample_busy_o) |-> prox_len == prox_exp)
    else $error("prox sample length wrong");

  chk_low_buffered: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R08]
    s_low_byte_write |=> $stable(als_thr.low))
    else $error("low byte applied before high byte");

  chk_pair_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R09]
    s_low_byte_write ##1 s_high_byte_write |=>
      als_thr.low == {$past(reg_req_i.wdata), $past(reg_req_i.wdata, 2)})
    else $error("threshold pair not latched together");

  chk_als_low_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R05]
    als_done_i && als_clear_i < als_thr.low && als_persistence_i == 4'h1 |=> als_irq_flag_o)
    else $error("als low crossing missed");

  chk_als_high_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R06]
    als_done_i && als_clear_i > als_thr.high && als_persistence_i == 4'h1 |=> als_irq_flag_o)
    else $error("als high crossing missed");

  chk_prox_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R12]
    prox_done_i && prox_result_i < prox_low_thresh && prox_persistence_i == 4'h1
      |=> prox_irq_flag_o)
    else $error("prox low crossing missed");

  chk_pers_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R14]
    als_done_i && als_clear_i >= als_thr.low && als_clear_i <= als_thr.high
      |=> als_cnt == '0 && !$rose(als_irq_flag_o) || als_persistence_i == 4'h0)
    else $error("als persistence not cleared");

  chk_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R18]
    als_irq_flag_o && !als_irq_clear_i |=> als_irq_flag_o)
    else $error("als flag dropped without clear");

  chk_prox_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R18]
    prox_irq_flag_o && !prox_irq_clear_i |=> prox_irq_flag_o)
    else $error("prox flag dropped without clear");

  chk_int_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [R07] [R13]
    int_o == ((als_irq_flag_o && als_irq_enable_i) || (prox_irq_flag_o && prox_irq_enable_i)))
    else $error("interrupt pin mismatch");
endmodule // aptr_regs
`default_nettype wire

/* aptr_host.sv */
// Host controller model for the register port of the threshold and timing bank
`timescale 1ns/10ps
`default_nettype none
module aptr_host (
  input wire logic sys_clk_i,
  output var aptr_pkg::aptr_reg_req_t reg_req_o,
  input wire logic [7:0] reg_rdata_i
);
  initial reg_req_o = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // Released fields show inverted bits, so a stale address never passes for a live one
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge sys_clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    @(posedge sys_clk_i);
    d = reg_rdata_i;
  endtask
  // Threshold bytes go low first, high on the very next edge
  task automatic wr_pair(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge sys_clk_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: lo};
    @(posedge sys_clk_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a + 8'h01, wdata: hi};
    @(posedge sys_clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~hi};
  endtask
endmodule // aptr_host
`default_nettype wire

/* testbench.sv */
// Self-checking testbench for the threshold and timing register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk_i, rst_n_i, lws, aen, pen, aclr, pclr, wst, pst, adone, pdone;
  logic wbusy, pbusy, aflag, pflag, irq;
  logic [7:0] rdata, rv, pres;
  logic [3:0] als_persistence, prox_persistence;
  logic [15:0] aval;
  aptr_pkg::aptr_reg_req_t req;
  int error_cnt, n_checks;
  aptr_regs #(.WAIT_UNIT_CYCLES(4)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .long_wait_select_i(lws),
    .als_persistence_i(als_persistence), .prox_persistence_i(prox_persistence), .als_irq_enable_i(aen),
    .prox_irq_enable_i(pen), .als_irq_clear_i(aclr), .prox_irq_clear_i(pclr),
    .wait_start_i(wst), .prox_sample_start_i(pst), .als_done_i(adone), .als_clear_i(aval),
    .prox_done_i(pdone), .prox_result_i(pres), .wait_busy_o(wbusy),
    .prox_sample_busy_o(pbusy), .als_irq_flag_o(aflag), .prox_irq_flag_o(pflag),
    .int_o(irq));
  aptr_host host (.sys_clk_i(sys_clk_i), .reg_req_o(req), .reg_rdata_i(rdata));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Flag is looked at one edge after the result is taken, as the designer settled
  task automatic meas(input logic p, input logic [15:0] v, input logic e);
    @(posedge sys_clk_i);
    pdone <= p;
    adone <= ~p;
    pres <= v[7:0];
    aval <= v;
    @(posedge sys_clk_i);
    pdone <= 1'b0;
    adone <= 1'b0;
    pres <= ~v[7:0];
    aval <= ~v;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(p ? "prox_irq_flag" : "als_irq_flag", {15'h0, e}, {15'h0, p ? pflag : aflag});
  endtask
  task automatic pers(input logic p, input int n, input logic [15:0] v);
    repeat (n - 1) meas(p, v, 1'b0);
    meas(p, v, 1'b1);
  endtask
  task automatic clr(input logic p);
    @(posedge sys_clk_i);
    pclr <= p;
    aclr <= ~p;
    @(posedge sys_clk_i);
    pclr <= 1'b0;
    aclr <= 1'b0;
  endtask
  task automatic en(input logic a, input logic p, input logic e);
    @(posedge sys_clk_i);
    aen <= a;
    pen <= p;
    @(negedge sys_clk_i);
    chk("int", {15'h0, e}, {15'h0, irq});
  endtask
  task automatic tmr(input logic p, input int e);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    pst <= p;
    wst <= ~p;
    @(posedge sys_clk_i);
    pst <= 1'b0;
    wst <= 1'b0;
    @(negedge sys_clk_i);
    while ((p ? pbusy : wbusy) === 1'b1 && n < 9000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(p ? "prox_sample_busy" : "wait_busy", e[15:0], n[15:0]);
    if (n >= 9000)
      end_of_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n_i, lws, aen, pen, aclr, pclr, wst, pst, adone, pdone} = '0;
    {pres, aval, error_cnt, n_checks} = '0;
    als_persistence = 4'h1;
    prox_persistence = 4'h1;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    chk("int", 16'h0000, {15'h0, irq});
    for (int i = 0; i < 8; i++)
    begin
      host.rd(8'h82 + i[7:0], rv);
      chk("reg", i == 0 ? 16'h001f : 16'h0000, {8'h00, rv});
    end
    host.wr(8'h89, 8'haa);
    host.rd(8'h89, rv);
    chk("unmapped", 16'h0000, {8'h00, rv});
    // High threshold of zero would flag every nonzero result, so open it up first
    host.wr_pair(8'h86, 8'hff, 8'hff);
    host.wr(8'h84, 8'h20);
    host.rd(8'h84, rv);
    chk("als_low_thresh_lo", 16'h0020, {8'h00, rv});
    meas(1'b0, 16'h0010, 1'b0);
    host.wr_pair(8'h84, 8'h00, 8'h01);
    meas(1'b0, 16'h00ff, 1'b1);
    meas(1'b0, 16'h0200, 1'b1);
    en(1'b0, 1'b1, 1'b0);
    en(1'b1, 1'b0, 1'b1);
    clr(1'b0);
    en(1'b1, 1'b0, 1'b0);
    @(posedge sys_clk_i) als_persistence <= 4'h2;
    meas(1'b0, 16'h0050, 1'b0);
    meas(1'b0, 16'h0200, 1'b0);
    pers(1'b0, 2, 16'h0050);
    clr(1'b0);
    als_persistence <= 4'h4;
    meas(1'b0, 16'h0200, 1'b0);
    pers(1'b0, 5, 16'h0050);
    clr(1'b0);
    als_persistence <= 4'h1;
    host.wr_pair(8'h86, 8'h00, 8'h10);
    meas(1'b0, 16'h1000, 1'b0);
    meas(1'b0, 16'h1001, 1'b1);
    clr(1'b0);
    // A zero setting flags every finished measurement, even a result inside the window
    als_persistence <= 4'h0;
    meas(1'b0, 16'h0800, 1'b1);
    clr(1'b0);
    host.wr(8'h88, 8'h40);
    meas(1'b1, 16'h0040, 1'b0);
    meas(1'b1, 16'h003f, 1'b1);
    en(1'b0, 1'b1, 1'b1);
    clr(1'b1);
    en(1'b0, 1'b1, 1'b0);
    @(posedge sys_clk_i) prox_persistence <= 4'h3;
    meas(1'b1, 16'h0080, 1'b0);
    pers(1'b1, 3, 16'h0010);
    host.rd(8'h87, rv);
    chk("als_high_thresh_hi", 16'h0010, {8'h00, rv});
    host.wr(8'h82, 8'h01);
    tmr(1'b1, 2 * aptr_pkg::PROX_UNIT_CYC);
    host.wr(8'h83, 8'h02);
    tmr(1'b0, 3 * 4);
    @(posedge sys_clk_i) lws <= 1'b1;
    tmr(1'b0, 3 * 4 * aptr_pkg::WAIT_LONG_FACTOR);
    host.rd(8'h83, rv);
    chk("wait_time", 16'h0002, {8'h00, rv});
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
